// file: hdl/acgf_defs.svh
// Register offsets, field positions, reset values and scaling constants
`ifndef ACGF_DEFS_SVH
`define ACGF_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ACGF_OFS_CTRL      12'h000
`define ACGF_OFS_CHCFG     12'h004
`define ACGF_OFS_REF       12'h040
`define ACGF_OFS_STATUS    12'h044
`define ACGF_OFS_COEF      12'h100

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACGF_CTRL_MASTER   0
`define ACGF_CTRL_UNLOCK   1
`define ACGF_CTRL_RATE_LSB 4
`define ACGF_REF_SEL       0
`define ACGF_REF_PD        1
`define ACGF_COEF_USER     15

// ----------------------------------------------------------------------
// Reset values and arithmetic constants
// ----------------------------------------------------------------------
`define ACGF_STATE_RST     '0
`define ACGF_GAIN_RST      4'h0
`define ACGF_GAIN_MAX      4'hC
`define ACGF_GAIN_FRAC     8
`define ACGF_SCALE_SHIFT   11
`define ACGF_NUM_COEF      12

`endif

// file: hdl/acgf_pkg.sv
// Types shared by the gain, FIR and decimation logic
package acgf_pkg;

    typedef enum logic [2:0] {
        ACGF_DEC2  = 3'h0,
        ACGF_DEC4  = 3'h1,
        ACGF_NODEC = 3'h3,
        ACGF_DEC8  = 3'h4
    } acgf_dec_t;

    typedef struct packed {
        logic       noise_shift_mode;
        logic       use_f;
        logic       odd;
        logic [2:0] shape;
        logic [2:0] dec;
        logic [3:0] gain;
    } acgf_chcfg_t;

endpackage : acgf_pkg

// file: hdl/acgf_fir.sv
// Symmetric FIR core for one channel: 24-tap, 23-tap and 12-tap forms
`timescale 1ns/1ps
`include "acgf_defs.svh"

module acgf_fir #(
    parameter int IN_W  = 12,
    parameter int OUT_W = 16,
    parameter int CW    = 12
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    shift_i,
    input  wire logic signed [IN_W-1:0]  sample_i,
    input  wire logic [12*CW-1:0]        coef_i,
    input  wire logic                    user_i,
    input  wire logic [2:0]              shape_i,
    input  wire logic                    odd_i,
    input  wire logic                    nodec_i,
    output logic signed [OUT_W-1:0]      y_o
);

    // ------------------------------------------------------------------
    // Built-in coefficient sets
    // ------------------------------------------------------------------
    typedef logic signed [11:0] acgf_coef_t;                          // [RULE7]
    localparam acgf_coef_t LP2 [12] = '{3, 0, 5, 1, -27, -2, 73, 3, -178, -4,
                                        636, 1024};                   // [RULE17]
    localparam acgf_coef_t HP2 [12] = '{-22, -65, -52, 30, 66, -35, -107, 38, 202, -41,
                                        -644, 1061};                  // [RULE18]
    localparam acgf_coef_t LP4 [12] = '{-17, -50, 71, 46, 24, -42, -100, 0, 0, 0, 0, 0};
    localparam acgf_coef_t BP4A[12] = '{-7, 19, -47, 127, 73, 0, 86, 0, 0, 0, 0, 0};
    localparam acgf_coef_t BP4B[12] = '{-34, -34, -101, 43, 58, -28, -5, 0, 0, 0, 0, 0};
    localparam acgf_coef_t HP4 [12] = '{40, -15, -95, 22, -8, -81, 106, 0, 0, 0, 0, 0};

    function automatic acgf_coef_t builtin(input logic [2:0] shape, input int k);
        case (shape)
            3'h0:    builtin = LP2[k];
            3'h1:    builtin = HP2[k];
            3'h2:    builtin = LP4[k];
            3'h3:    builtin = BP4A[k];
            3'h4:    builtin = BP4B[k];
            3'h5:    builtin = HP4[k];
            default: builtin = 12'sh000;
        endcase
    endfunction : builtin

    // ------------------------------------------------------------------
    // Delay line, x(n) at index 0
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [23:0][IN_W-1:0] line;
    } acgf_fir_state_t;

    acgf_fir_state_t st;
    acgf_fir_state_t next_st;

    always_comb begin
        next_st = st;
        if (shift_i) begin
            next_st.line[0] = sample_i;
            for (int i = 1; i < 24; i++) begin
                next_st.line[i] = st.line[i-1];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= `ACGF_STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Folded multiply-accumulate over the line including x(n)
    // ------------------------------------------------------------------
    logic signed [29:0] acc;
    logic signed [29:0] scaled;

    always_comb begin
        acgf_coef_t       h;
        logic signed [IN_W:0] pair;
        h    = 12'sh000;
        pair = '0;
        acc  = '0;
        for (int k = 0; k < 12; k++) begin
            h = user_i ? acgf_coef_t'(coef_i[k*CW +: CW]) : builtin(shape_i, k); // [RULE21]
            if (nodec_i) begin
                pair = (k >= 6) ? $signed(next_st.line[k % 6]) + $signed(next_st.line[17-k])
                                : (IN_W+1)'(0);
            end else if (odd_i) begin
                pair = (k < 11) ? $signed(next_st.line[k]) + $signed(next_st.line[22-k])
                                : (IN_W+1)'($signed(next_st.line[11]));       // [RULE6]
            end else begin
                pair = $signed(next_st.line[k]) + $signed(next_st.line[23-k]); // [RULE5]
            end
            acc = acc + 30'(h * pair);
        end
        scaled = acc >>> `ACGF_SCALE_SHIFT;                           // [RULE5] [RULE6]
        if (scaled > 30'sd32767) begin
            y_o = 16'sh7FFF;
        end else if (scaled < -30'sd32768) begin
            y_o = -16'sh8000;
        end else begin
            y_o = OUT_W'(scaled);
        end
    end

endmodule : acgf_fir

// file: hdl/acgf_top.sv
// Eight-channel gain, noise shift, FIR decimation and reference control
//
// Contract
// RULE1: Per-channel gain 0 to 12 dB, 1 dB steps
// RULE2: Reset leaves every channel at 0 dB
// RULE3: Host writes only gain codes 0 to 12
// RULE4: Decimate by 2, 4, 8 with several shapes
// RULE5: Even form: 24-tap symmetric, scaled by 2^-11
// RULE6: Odd form: 23-tap, centre tap h11
// RULE7: Coefficients are 12-bit signed two's complement
// RULE8: Host setting for built-in decimate-2 low-pass
// RULE9: Host setting for built-in decimate-2 high-pass
// RULE10: Host setting for built-in decimate-4 low-pass
// RULE11: Host setting for decimate-4 first band-pass
// RULE12: Host setting for decimate-4 second band-pass
// RULE13: Host setting for built-in decimate-4 high-pass
// RULE14: Host setting for user taps, ratios 2/4/8
// RULE15: Host setting for 12-tap filter, no decimation
// RULE16: Host programs identical decimation in all channels
// RULE17: Built-in decimate-2 low-pass coefficient set
// RULE18: Built-in decimate-2 high-pass coefficient set
// RULE19: Noise shift moves dc band to half rate
// RULE20: Unlock plus outside reference powers reference amplifiers down
// RULE21: User taps bit picks user or built-in coefficients
// RULE22: Host sets unlock before writing reference select
// RULE23: Filter disabled passes gained samples unchanged
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "acgf_defs.svh"

module acgf_top #(
    parameter int NUM_CH = 8,
    parameter int IN_W   = 12,
    parameter int OUT_W  = 16
) (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [11:0]               wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire logic                      sample_valid_i,
    input  wire logic [NUM_CH*IN_W-1:0]    sample_i,
    output logic      [NUM_CH-1:0]         out_valid_o,
    output logic      [NUM_CH*OUT_W-1:0]   out_data_o,
    output logic                           ref_amp_powerdown_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                                  master;
        logic                                  unlock;
        logic [1:0]                            rate;
        logic                                  ext_ref;
        acgf_pkg::acgf_chcfg_t [NUM_CH-1:0]    cfg;
        logic [NUM_CH-1:0]                     user;
        logic [NUM_CH*12-1:0][11:0]            coef;
        logic [2:0]                            phase;
        logic                                  noise_shift_mode_odd;
        logic [15:0]                           out_count;
        logic                                  ack;
        logic [31:0]                           rdat;
        logic [NUM_CH-1:0]                     ovalid;
        logic [NUM_CH-1:0][OUT_W-1:0]          odata;
        logic                                  pd;
    } acgf_state_t;

    acgf_state_t st;
    acgf_state_t next_st;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [10:0] gain_factor(input logic [3:0] code);
        case (code)
            4'h0:    gain_factor = 11'h100;
            4'h1:    gain_factor = 11'h11F;
            4'h2:    gain_factor = 11'h143;
            4'h3:    gain_factor = 11'h16A;
            4'h4:    gain_factor = 11'h196;
            4'h5:    gain_factor = 11'h1C8;
            4'h6:    gain_factor = 11'h1FF;
            4'h7:    gain_factor = 11'h23D;
            4'h8:    gain_factor = 11'h283;
            4'h9:    gain_factor = 11'h2D2;
            4'hA:    gain_factor = 11'h32A;
            4'hB:    gain_factor = 11'h38D;
            4'hC:    gain_factor = 11'h3FC;
            default: gain_factor = 11'h100;
        endcase
    endfunction : gain_factor

    function automatic logic signed [IN_W-1:0] sat_in(input logic signed [23:0] v);
        if (v > 24'sd2047) begin
            sat_in = 12'sh7FF;
        end else if (v < -24'sd2048) begin
            sat_in = -12'sh800;
        end else begin
            sat_in = IN_W'(v);
        end
    endfunction : sat_in

    function automatic logic [2:0] dec_last(input logic [2:0] dec);
        case (dec)
            3'(acgf_pkg::ACGF_DEC2): dec_last = 3'h1;
            3'(acgf_pkg::ACGF_DEC4): dec_last = 3'h3;
            3'(acgf_pkg::ACGF_DEC8): dec_last = 3'h7;
            default:                 dec_last = 3'h0;
        endcase
    endfunction : dec_last

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                            input logic [1:0] sel);
        merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    // ------------------------------------------------------------------
    // Noise shift and gain ahead of the filters
    // ------------------------------------------------------------------
    logic signed [IN_W-1:0]  gained [NUM_CH];
    logic signed [OUT_W-1:0] fir_y  [NUM_CH];

    always_comb begin
        logic signed [IN_W-1:0] raw;
        raw = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            raw = $signed(sample_i[c*IN_W +: IN_W]);
            if (st.cfg[c].noise_shift_mode && st.noise_shift_mode_odd) begin
                raw = (raw == -12'sh800) ? 12'sh7FF : -raw;            // [RULE19]
            end
            gained[c] = sat_in((raw * $signed({1'b0, gain_factor(st.cfg[c].gain)}))
                               >>> `ACGF_GAIN_FRAC);                    // [RULE1]
        end
    end

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        acgf_fir #(
            .IN_W  (IN_W),
            .OUT_W (OUT_W),
            .CW    (12)
        ) i_acgf_fir (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .shift_i  (sample_valid_i),
            .sample_i (gained[g]),
            .coef_i   (st.coef[g*12 +: 12]),
            .user_i   (st.user[g]),
            .shape_i  (st.cfg[g].shape),
            .odd_i    (st.cfg[g].odd),
            .nodec_i  (st.cfg[g].dec == 3'(acgf_pkg::ACGF_NODEC)),
            .y_o      (fir_y[g])
        );
    end

    // ------------------------------------------------------------------
    // Register bus, decimation and output stage
    // ------------------------------------------------------------------
    always_comb begin
        logic        req;
        logic [15:0] old;
        logic [15:0] wv;
        logic [9:0]  ci;
        int          ch;
        int          cidx;
        logic        last;
        next_st = st;
        req     = wb_cyc_i & wb_stb_i & ~st.ack;
        old     = 16'h0000;
        wv      = 16'h0000;
        last    = 1'b0;
        ci      = 10'((wb_adr_i - `ACGF_OFS_COEF) >> 2);
        ch      = int'(ci) / 12;
        cidx    = int'(wb_adr_i - `ACGF_OFS_CHCFG) >> 2;
        next_st.ack = req;
        if (wb_adr_i == `ACGF_OFS_CTRL) begin
            old[`ACGF_CTRL_MASTER] = st.master;
            old[`ACGF_CTRL_UNLOCK] = st.unlock;
            old[`ACGF_CTRL_RATE_LSB +: 2] = st.rate;
        end else if (wb_adr_i >= `ACGF_OFS_CHCFG && cidx < NUM_CH) begin
            old = 16'(st.cfg[cidx]);
        end else if (wb_adr_i == `ACGF_OFS_REF) begin
            old[`ACGF_REF_SEL] = st.ext_ref;
            old[`ACGF_REF_PD]  = st.pd;
        end else if (wb_adr_i == `ACGF_OFS_STATUS) begin
            old = st.out_count;
        end else if (wb_adr_i >= `ACGF_OFS_COEF && int'(ci) < NUM_CH*12) begin
            old = {st.user[ch], 3'h0, st.coef[ci]};
        end
        wv = merge16(old, wb_dat_i[15:0], wb_sel_i[1:0]);
        if (req) begin
            next_st.rdat = {16'h0000, old};
        end
        if (req && wb_we_i) begin
            if (wb_adr_i == `ACGF_OFS_CTRL) begin
                next_st.master = wv[`ACGF_CTRL_MASTER];
                next_st.unlock = wv[`ACGF_CTRL_UNLOCK];
                next_st.rate   = wv[`ACGF_CTRL_RATE_LSB +: 2];
            end else if (wb_adr_i >= `ACGF_OFS_CHCFG && cidx < NUM_CH) begin
                next_st.cfg[cidx] = wv[12:0];
            end else if (wb_adr_i == `ACGF_OFS_REF && st.unlock) begin
                next_st.ext_ref = wv[`ACGF_REF_SEL];                    // [RULE22]
            end else if (wb_adr_i >= `ACGF_OFS_COEF && int'(ci) < NUM_CH*12) begin
                next_st.coef[ci]   = wv[11:0];
                next_st.user[ch]   = wv[`ACGF_COEF_USER];               // [RULE21]
            end
        end
        next_st.pd = next_st.ext_ref & next_st.unlock;                 // [RULE20]
        last = (st.phase == dec_last(st.cfg[0].dec));
        next_st.ovalid = '0;
        if (sample_valid_i) begin
            next_st.phase    = last ? 3'h0 : st.phase + 3'h1;          // [RULE4]
            next_st.noise_shift_mode_odd = ~st.noise_shift_mode_odd;                           // [RULE19]
            for (int c = 0; c < NUM_CH; c++) begin
                if (st.master && st.cfg[c].use_f) begin
                    next_st.ovalid[c] = last;                          // [RULE4]
                    next_st.odata[c]  = fir_y[c];
                end else begin
                    next_st.ovalid[c] = 1'b1;                          // [RULE23]
                    next_st.odata[c]  = OUT_W'(gained[c]);
                end
            end
            if (next_st.ovalid[0]) begin
                next_st.out_count = st.out_count + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= `ACGF_STATE_RST;                                     // [RULE2]
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_o            = st.ack;
    assign wb_dat_o            = st.rdat;
    assign out_valid_o         = st.ovalid;
    assign out_data_o          = st.odata;
    assign ref_amp_powerdown_o = st.pd;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic off0;
    assign off0 = !(st.master && st.cfg[0].use_f) && !st.cfg[0].noise_shift_mode;

    chk_gain_reset: assert property (@(posedge clk_i) $past(rst_i) |-> // [RULE2]
        st.cfg[0].gain == `ACGF_GAIN_RST && st.cfg[NUM_CH-1].gain == `ACGF_GAIN_RST)
        else $error("gain not 0 dB after reset");
    chk_gain_unity: assert property (sample_valid_i && off0 && st.cfg[0].gain == 4'h0 // [RULE23]
        |=> out_valid_o[0] && $signed(out_data_o[OUT_W-1:0]) == $signed($past(sample_i[IN_W-1:0])))
        else $error("unity pass-through mismatch");
    chk_gain_twelve: assert property (sample_valid_i && off0 && st.cfg[0].gain == 4'hC // [RULE1]
        && sample_i[IN_W-1:0] == 12'h064 |=> out_data_o[OUT_W-1:0] == 16'h018E)
        else $error("12 dB gain wrong");
    chk_dec_spacing: assert property (st.master && st.cfg[0].use_f // [RULE4]
        && st.cfg[0].dec == 3'h0 && out_valid_o[0] |=> !out_valid_o[0])
        else $error("decimate-by-2 output too dense");
    chk_dec_four: assert property ((st.master && st.cfg[0].use_f // [RULE4]
        && st.cfg[0].dec == 3'h1 && sample_valid_i)[*4] |=> $past(out_valid_o[0], 3)
        || $past(out_valid_o[0], 2) || $past(out_valid_o[0], 1) || out_valid_o[0])
        else $error("decimate-by-4 output missing");
    chk_ref_locked: assert property (!st.unlock ##1 1 // [RULE22]
        |-> st.ext_ref == $past(st.ext_ref))
        else $error("reference select changed while locked");
    chk_ref_powerdown: assert property (st.ext_ref && st.unlock // [RULE20]
        |-> ref_amp_powerdown_o)
        else $error("reference amplifiers not powered down");
    chk_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_noise_shift_mode_alt: assert property ((sample_valid_i && st.cfg[0].noise_shift_mode && !(st.master // [RULE19]
        && st.cfg[0].use_f) && st.cfg[0].gain == 4'h0 && sample_i[IN_W-1:0] == 12'h010)[*2]
        |=> out_data_o[OUT_W-1:0] == 16'(-$signed($past(out_data_o[OUT_W-1:0]))))
        else $error("noise shift did not alternate sign");
    chk_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    chk_nodec_rate: assert property (st.master && st.cfg[0].use_f // [RULE4]
        && st.cfg[0].dec == 3'h3 && sample_valid_i |=> out_valid_o[0])
        else $error("undecimated output missing");
    chk_pass_valid: assert property (sample_valid_i && !st.master |=> &out_valid_o) // [RULE23]
        else $error("pass-through output missing");

endmodule : acgf_top

// file: tb/acgf_host_model.sv
// Host model: register bus master and receiver of the channel outputs
`timescale 1ns/1ps
`include "acgf_defs.svh"

module acgf_host_model #(
    parameter int NUM_CH = 8,
    parameter int OUT_W  = 16
) (
    input  wire logic                    clk_i,
    output logic                         cyc_o,
    output logic                         stb_o,
    output logic                         we_o,
    output logic [11:0]                  adr_o,
    output logic [3:0]                   sel_o,
    output logic [31:0]                  dat_o,
    input  wire logic [31:0]             dat_i,
    input  wire logic                    ack_i,
    input  wire logic [NUM_CH-1:0]       vld_i,
    input  wire logic [NUM_CH*OUT_W-1:0] data_i
);
    int               rx_count = 0;
    logic [OUT_W-1:0] rx_last [NUM_CH];

    // ----------------------------------------------------------------
    // Bus master
    // ----------------------------------------------------------------
    initial begin
        {cyc_o, stb_o, we_o} = 3'h0;
        adr_o = 12'h000;
        sel_o = 4'h0;
        dat_o = 32'h00000000;
    end

    task automatic xfer(input logic we, input logic [11:0] adr, input logic [31:0] wd,
                        output logic [31:0] rd);
        {cyc_o, stb_o, we_o} <= {2'h3, we};
        adr_o <= adr;
        sel_o <= 4'h3;
        dat_o <= wd;
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        rd = dat_i;
        {cyc_o, stb_o, we_o} <= 3'h0;
        adr_o <= ~adr;
        dat_o <= ~wd;
        @(posedge clk_i);
    endtask : xfer

    task automatic wb_write(input logic [11:0] adr, input logic [31:0] wd);
        logic [31:0] d;
        xfer(1'b1, adr, wd, d);
    endtask : wb_write

    task automatic wb_read(input logic [11:0] adr, output logic [31:0] rd);
        xfer(1'b0, adr, 32'h00000000, rd);
    endtask : wb_read

    // Same word, and so the same decimation, in every channel
    task automatic setup(input logic [31:0] ctrl, input logic [31:0] chcfg);
        wb_write(`ACGF_OFS_CTRL, ctrl);
        for (int c = 0; c < NUM_CH; c++) wb_write(`ACGF_OFS_CHCFG + 12'(4 * c), chcfg);
    endtask : setup

    // Coefficient h11 only, all others zero; every word carries the user bit
    task automatic load_coef(input logic user, input logic [11:0] h11);
        for (int w = 0; w < NUM_CH * 12; w++) begin
            wb_write(`ACGF_OFS_COEF + 12'(4 * w),
                     {16'h0000, user, 3'h0, (w % 12 == 11) ? h11 : 12'h000});
        end
    endtask : load_coef

    // ----------------------------------------------------------------
    // Output receiver
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (vld_i[c] === 1'b1) rx_last[c] <= data_i[c*OUT_W +: OUT_W];
        end
        if (vld_i[0] === 1'b1) rx_count <= rx_count + 1;
    end
endmodule : acgf_host_model

// file: tb/acgf_tb.sv
// Testbench for the gain, noise shift, FIR decimation and reference block
`timescale 1ns/1ps
`include "acgf_defs.svh"

module adc_channel_gain_fir_decimator_test;
    localparam int NCH = 8;
    logic            clk_i, rst_i, sample_valid_i, cyc, stb, we, ack, pd;
    logic [11:0]     adr;
    logic [3:0]      sel;
    logic [31:0]     wdat, rdat;
    logic [NCH*12-1:0] sample_i;
    logic [NCH-1:0]    vld;
    logic [NCH*16-1:0] odat;
    int              fails = 0, compares = 0, cycles = 0;

    acgf_top #(.NUM_CH(NCH), .IN_W(12), .OUT_W(16)) i_acgf_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sample_valid_i(sample_valid_i), .sample_i(sample_i), .out_valid_o(vld),
        .out_data_o(odat), .ref_amp_powerdown_o(pd));
    acgf_host_model #(.NUM_CH(NCH), .OUT_W(16)) i_acgf_host_model (
        .clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
        .dat_o(wdat), .dat_i(rdat), .ack_i(ack), .vld_i(vld), .data_i(odat));

    // ----------------------------------------------------------------
    // Clock, watchdog and helpers
    // ----------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        i_acgf_host_model.wb_read(a, d);
        check(d, exp);
    endtask : rd

    task automatic feed(input int n, input logic [11:0] x);
        repeat (n) begin
            sample_valid_i <= 1'b1;
            sample_i <= {NCH{x}};
            @(posedge clk_i);
        end
        sample_valid_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : feed

    task automatic run(input logic [1:0] rate, input logic mst, input acgf_pkg::acgf_chcfg_t cc,
                       input int ratio, input logic [15:0] exp);
        int c0;
        i_acgf_host_model.setup({26'h0, rate, 3'h0, mst}, 32'(cc));
        c0 = i_acgf_host_model.rx_count;
        feed(48, 12'h3E8);
        check(32'(i_acgf_host_model.rx_count - c0), 32'(48 / ratio));
        for (int c = 0; c < NCH; c++) check(32'(i_acgf_host_model.rx_last[c]), 32'(exp));
    endtask : run

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        acgf_pkg::acgf_chcfg_t cc;
        logic [15:0] n1;
        int e, g;
        rst_i = 1'b1;
        sample_valid_i = 1'b0;
        sample_i = '0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        for (int c = 0; c < NCH; c++) rd(`ACGF_OFS_CHCFG + 12'(4 * c), 32'h0);
        i_acgf_host_model.wb_write(12'hFF0, 32'h0000FFFF);
        rd(12'hFF0, 32'h0);
        feed(1, 12'h064);
        check(32'(i_acgf_host_model.rx_last[5]), 32'h0064);
        cc = '0;
        for (int d = 0; d <= 12; d++) begin
            cc.gain = 4'(d);
            i_acgf_host_model.setup(32'h0, 32'(cc));
            feed(1, 12'h064);
            e = $rtoi(100.0 * 10.0 ** (d / 20.0));
            g = int'($signed(i_acgf_host_model.rx_last[3]));
            compares++;
            if (g < e - 1 || g > e + 1) begin
                fails++;
                $display("[FAIL] %0t gain %0d got %0d", $time, d, g);
            end
        end
        feed(1, 12'h7FF);
        check(32'(i_acgf_host_model.rx_last[0]), 32'h07FF);
        feed(1, 12'h800);
        check(32'(i_acgf_host_model.rx_last[0]), 32'hF800);
        cc = '0;
        cc.noise_shift_mode = 1'b1;
        i_acgf_host_model.setup(32'h0, 32'(cc));
        feed(1, 12'h064);
        n1 = i_acgf_host_model.rx_last[1];
        feed(1, 12'h064);
        check(32'(16'(n1 + i_acgf_host_model.rx_last[1])), 32'h0);
        check({31'h0, n1 === 16'h0064 || n1 === 16'hFF9C}, 32'h1);
        feed(2, 12'h010);
        check(32'(i_acgf_host_model.rx_last[1]), 32'hFFF0);
        cc = '0;
        cc.use_f = 1'b1;
        cc.dec = acgf_pkg::ACGF_NODEC;
        i_acgf_host_model.load_coef(1'b1, 12'h800);
        run(2'h0, 1'b1, cc, 1, 16'hF830);
        cc.dec = acgf_pkg::ACGF_DEC2;
        cc.odd = 1'b1;
        run(2'h1, 1'b1, cc, 2, 16'hFC18);
        i_acgf_host_model.load_coef(1'b0, 12'h800);
        run(2'h1, 1'b1, cc, 2, 16'h03E6);
        cc.shape = 3'h1;
        run(2'h1, 1'b1, cc, 2, 16'hFF9E);
        cc.dec = acgf_pkg::ACGF_DEC4;
        cc.odd = 1'b0;
        cc.shape = 3'h2;
        run(2'h2, 1'b1, cc, 4, 16'hFFBD);
        cc.shape = 3'h3;
        run(2'h2, 1'b1, cc, 4, 16'h00F5);
        cc.shape = 3'h4;
        run(2'h2, 1'b1, cc, 4, 16'hFF9D);
        cc.shape = 3'h5;
        cc.odd = 1'b1;
        run(2'h2, 1'b1, cc, 4, 16'hFFE1);
        cc.shape = 3'h0;
        cc.odd = 1'b0;
        i_acgf_host_model.load_coef(1'b1, 12'h800);
        run(2'h2, 1'b1, cc, 4, 16'hF830);
        cc.dec = acgf_pkg::ACGF_DEC8;
        run(2'h3, 1'b1, cc, 8, 16'hF830);
        run(2'h3, 1'b0, cc, 1, 16'h03E8);
        i_acgf_host_model.wb_write(`ACGF_OFS_REF, 32'h1);
        rd(`ACGF_OFS_REF, 32'h0);
        i_acgf_host_model.wb_write(`ACGF_OFS_CTRL, 32'h2);
        i_acgf_host_model.wb_write(`ACGF_OFS_REF, 32'h1);
        rd(`ACGF_OFS_REF, 32'h3);
        check({31'h0, pd}, 32'h1);
        rd(`ACGF_OFS_STATUS, 32'(i_acgf_host_model.rx_count));
        end_of_test();
    end
endmodule : adc_channel_gain_fir_decimator_test
